/* core/hwn_notify.sv */
`timescale 1ns/100ps
// Notes on behaviour
// - switch enable raised before each interrupt pulse when ps_switch_cfg_in is set
// - serial on: select pin is active-low select
// - serial off: low select level raises wake
// - after wake-up, assert ready level on pin
// - attention events drive a pulse on pin
// - drive client-out, sample client-in data
// - strap low at reset release: debug mode
// - strap pin is output-only as gpio
// - clock idles low, capture rise, change fall
// - each register access is 16 clocks
// - frames carry even parity, checked on receive
module hwn_notify
    import hwn_pkg::*;
(
    // clock and reset
    input wire logic ref_clk_in,
    input wire logic rst_n_in,
    // configuration from device logic
    input wire logic serial_enable_in,
    input wire logic ps_switch_cfg_in,
    input wire logic attention_in,
    input wire logic gpio_mode_in,
    input wire logic gpio_value_in,
    input wire logic [FRAME_BITS-1:0] tx_word_in,
    // pins from the host
    input wire logic port_a_bit0_pin_in,
    input wire logic serial_clk_pin_in,
    input wire logic client_in_line_in,
    input wire logic debug_strap_pin_in,
    // pins to the host
    output logic client_out_line_out,
    output hwn_drive_s port_b_bit0_pin_out,
    output logic power_switch_enable_out,
    output hwn_drive_s debug_strap_pin_out,
    // status to device logic
    output logic wake_irq_out,
    output logic background_debug_state_out,
    output logic rx_valid_out,
    output hwn_frame_s rx_frame_out
);
    // pin synchronisers; first stage is read only by the second
    logic sel_m_q, sel_s_q, sel_p_q; // select / wake, idles high
    logic clk_m_q, clk_s_q, clk_p_q; // serial clock, idles low
    logic din_m_q, din_s_q; // client-in data
    logic strap_m_q, strap_s_q; // debug strap, pulled up

    // sync stages only register pins, reset to the idle levels
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            {sel_m_q, sel_s_q, sel_p_q} <= {3{SYNC_IDLE_HI}};
            {clk_m_q, clk_s_q, clk_p_q} <= {3{SYNC_IDLE_LO}};
            {din_m_q, din_s_q} <= {2{SYNC_IDLE_LO}};
            {strap_m_q, strap_s_q} <= {2{SYNC_IDLE_HI}};
        end
        else
        begin
            {sel_m_q, sel_s_q, sel_p_q} <=
                {port_a_bit0_pin_in, sel_m_q, sel_s_q};
            {clk_m_q, clk_s_q, clk_p_q} <=
                {serial_clk_pin_in, clk_m_q, clk_s_q};
            {din_m_q, din_s_q} <= {client_in_line_in, din_m_q};
            {strap_m_q, strap_s_q} <= {debug_strap_pin_in, strap_m_q};
        end
    end

    // decoded pin events, all from settled stages
    logic selected; // select active in serial mode
    logic wake_lvl; // low level while serial is off
    logic clk_rise, clk_fall;
    logic sel_rise; // host ended a session
    assign selected = serial_enable_in && !sel_s_q;
    assign wake_lvl = !serial_enable_in && !sel_s_q;
    assign clk_rise = clk_s_q && !clk_p_q;
    assign clk_fall = !clk_s_q && clk_p_q;
    assign sel_rise = sel_s_q && !sel_p_q;

    // serial shifter state; clock is only ever an input
    logic [FRAME_BITS-1:0] tx_q, tx_d; // response bits still to send
    logic [FRAME_BITS-1:0] rx_q, rx_d; // command bits gathered
    logic [3:0] bit_q, bit_d; // bits taken this frame
    logic dout_q, dout_d;
    logic rxv_q, rxv_d;
    hwn_frame_s frm_q, frm_d;
    logic wake_q, wake_d;
    logic [FRAME_BITS-1:0] tx_fill; // response with parity in lsb

    // parity bit makes the whole response word even
    assign tx_fill = {tx_word_in[MSB:1], ^tx_word_in[MSB:1]};

    // next values for the serial shifter
    always_comb
    begin
        tx_d = tx_q;
        rx_d = rx_q;
        bit_d = bit_q;
        rxv_d = 1'b0;
        frm_d = frm_q;
        wake_d = wake_lvl; // level sensed, no edge needed
        if (!selected)
        begin
            // idle: reload response so bit one is out before first rise
            tx_d = tx_fill;
            bit_d = '0;
        end
        else
        begin
            if (clk_rise) // sample host data
            begin
                rx_d = {rx_q[MSB-1:0], din_s_q};
                bit_d = bit_q + BIT_ONE;
                if (bit_q == LAST_BIT) // frame of 16 clocks
                begin
                    rxv_d = 1'b1;
                    frm_d.word = {rx_q[MSB-1:0], din_s_q};
                    frm_d.parity_err = ^{rx_q[MSB-1:0], din_s_q};
                end
            end
            if (clk_fall) // change data on falling edge
            begin
                tx_d = {tx_q[MSB-1:0], 1'b0};
            end
        end
        dout_d = tx_d[MSB];
    end

    // register the serial shifter
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            tx_q <= '0;
            rx_q <= '0;
            bit_q <= '0;
            dout_q <= 1'b0;
            rxv_q <= 1'b0;
            frm_q <= '0;
            wake_q <= 1'b0;
        end
        else
        begin
            tx_q <= tx_d;
            rx_q <= rx_d;
            bit_q <= bit_d;
            dout_q <= dout_d;
            rxv_q <= rxv_d;
            frm_q <= frm_d;
            wake_q <= wake_d;
        end
    end

    // ready and interrupt pin sequencer
    hwn_state_e st_q, st_d;
    logic pend_q, pend_d; // attention waiting for the pin
    logic [7:0] cnt_q, cnt_d; // lead and pulse timer
    logic pse_q, pse_d; // power switch enable
    logic session_q, session_d; // select seen low since ready
    hwn_drive_s pin_q, pin_d; // ready and interrupt pin drive

    // a ready level holds the pin, so attention waits until release
    always_comb
    begin
        st_d = st_q;
        cnt_d = cnt_q;
        pse_d = pse_q;
        session_d = session_q;
        // a new event beats the clear in the same cycle
        pend_d = pend_q || attention_in;
        if (cnt_q != '0)
        begin
            cnt_d = cnt_q - CNT_ONE;
        end
        case (st_q)
            HWN_IDLE:
            begin
                if (wake_q)
                begin
                    st_d = HWN_READY;
                    session_d = 1'b0;
                end
                else if (pend_q && ps_switch_cfg_in)
                begin
                    st_d = HWN_LEAD;
                    pse_d = 1'b1;
                    cnt_d = PS_LEAD_CYC;
                end
                else if (pend_q)
                begin
                    st_d = HWN_PULSE;
                    cnt_d = PULSE_CYC;
                end
            end
            HWN_READY:
            begin
                if (selected)
                begin
                    session_d = 1'b1;
                end
                if (session_q && sel_rise)
                begin
                    st_d = HWN_IDLE;
                end
            end
            HWN_LEAD:
            begin
                if (cnt_q == CNT_ONE)
                begin
                    st_d = HWN_PULSE; // switch already high
                    cnt_d = PULSE_CYC;
                end
            end
            HWN_PULSE:
            begin
                if (cnt_q == CNT_ONE)
                begin
                    st_d = HWN_IDLE;
                    pse_d = 1'b0;
                    pend_d = attention_in; // clear, set wins
                end
            end
            default:
            begin
                st_d = HWN_IDLE;
            end
        endcase
        // pin taken from the next state so it tracks st_q exactly
        pin_d.out = NOTIFY_ACTIVE;
        pin_d.oe = (st_d == HWN_READY) || (st_d == HWN_PULSE);
    end

    // register the sequencer
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            st_q <= HWN_IDLE;
            pend_q <= 1'b0;
            cnt_q <= '0;
            pse_q <= 1'b0;
            session_q <= 1'b0;
        end
        else
        begin
            st_q <= st_d;
            pend_q <= pend_d;
            cnt_q <= cnt_d;
            pse_q <= pse_d;
            session_q <= session_d;
        end
    end

    // strap capture after reset release, gpio drive of the strap pin
    logic [1:0] settle_q, settle_d;
    logic dbg_q, dbg_d;
    hwn_drive_s gpio_q, gpio_d;

    // strap sampled once the synchroniser holds post-reset levels
    always_comb
    begin
        settle_d = settle_q;
        dbg_d = dbg_q;
        if (settle_q != STRAP_SETTLE)
        begin
            settle_d = settle_q + STRAP_ONE;
            if (settle_d == STRAP_SETTLE)
            begin
                dbg_d = !strap_s_q;
            end
        end
        // as gpio the pin never reads, only drives
        gpio_d.oe = gpio_mode_in;
        gpio_d.out = gpio_mode_in && gpio_value_in;
    end

    // register strap and pin drives
    always_ff @(posedge ref_clk_in)
    begin
        if (!rst_n_in)
        begin
            settle_q <= '0;
            dbg_q <= 1'b0;
            gpio_q <= '0;
            pin_q <= '0;
        end
        else
        begin
            settle_q <= settle_d;
            dbg_q <= dbg_d;
            gpio_q <= gpio_d;
            pin_q <= pin_d;
        end
    end

    // outputs straight from flops
    assign client_out_line_out = dout_q;
    assign port_b_bit0_pin_out = pin_q;
    assign power_switch_enable_out = pse_q;
    assign debug_strap_pin_out = gpio_q;
    assign wake_irq_out = wake_q;
    assign background_debug_state_out = dbg_q;
    assign rx_valid_out = rxv_q;
    assign rx_frame_out = frm_q;

    // last cycle of an attention pulse, counted from its first
    localparam int PULSE_LAST = int'(PULSE_CYC - CNT_ONE);

    // checks
    ps_before_pulse_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) $rose(st_q == HWN_PULSE) && ps_switch_cfg_in
        |-> power_switch_enable_out && $past(power_switch_enable_out))
        else $error("pulse without switch enable lead");
    wake_ready_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) st_q == HWN_IDLE && wake_q
        |=> st_q == HWN_READY ##1 port_b_bit0_pin_out.oe)
        else $error("wake did not raise ready");
    wake_level_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) serial_enable_in [*3] |-> !wake_irq_out)
        else $error("wake raised while serial on");
    ready_release_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) st_q == HWN_READY && session_q && sel_rise
        |=> !port_b_bit0_pin_out.oe)
        else $error("ready not released at session end");
    pulse_width_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) $rose(st_q == HWN_PULSE)
        |-> ##PULSE_LAST st_q == HWN_PULSE ##1 st_q == HWN_IDLE)
        else $error("pulse width wrong");
    frame_len_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) rx_valid_out
        |-> $past(bit_q) == LAST_BIT && bit_q == '0)
        else $error("frame not 16 clocks");
    parity_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) rx_valid_out
        |-> rx_frame_out.parity_err == ^rx_frame_out.word)
        else $error("parity flag wrong");
    strap_hold_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) settle_q == STRAP_SETTLE
        |=> $stable(background_debug_state_out))
        else $error("debug state changed after capture");
    gpio_out_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) gpio_mode_in |=> debug_strap_pin_out.oe)
        else $error("gpio strap pin not driving");
    shift_fall_a: assert property (@(posedge ref_clk_in)
        disable iff (!rst_n_in) selected && !clk_fall && !$fell(selected)
        |=> $stable(tx_q))
        else $error("data changed off falling edge");
endmodule

/* core/hwn_pkg.sv */
// shared constants and types for the host wake and notify logic
package hwn_pkg;
    // clock and timing
    localparam int CLK_PERIOD_NS = 50; // 20 mhz reference clock
    localparam int PS_LEAD_NS = 1000; // switch enable lead before a pulse
    localparam int PULSE_NS = 2000; // width of an attention pulse
    // least times round up to whole cycles
    localparam logic [7:0] PS_LEAD_CYC =
        8'((PS_LEAD_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] PULSE_CYC =
        8'((PULSE_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS);
    localparam logic [7:0] CNT_ONE = 8'h01;
    // serial frame layout
    localparam int FRAME_BITS = 16; // one command or response word
    localparam logic [3:0] LAST_BIT = 4'hF; // index of last bit in a frame
    localparam logic [3:0] BIT_ONE = 4'h1;
    localparam int MSB = FRAME_BITS - 1; // first bit on the wire
    // reset holds the strap synchroniser at idle, so capture waits
    // until both stages hold the pin level again
    localparam logic [1:0] STRAP_SETTLE = 2'h3;
    localparam logic [1:0] STRAP_ONE = 2'h1;
    // idle levels of pins through the synchronisers
    localparam logic SYNC_IDLE_HI = 1'h1;
    localparam logic SYNC_IDLE_LO = 1'h0;
    // active level of the ready and interrupt pin
    localparam logic NOTIFY_ACTIVE = 1'h1;

    // ready and interrupt pin sequencer, one-hot
    typedef enum logic [3:0] {
        HWN_IDLE = 4'h1, // pin released to the host pull
        HWN_READY = 4'h2, // ready level after a wake-up
        HWN_LEAD = 4'h4, // switch enable raised, pulse pending
        HWN_PULSE = 4'h8 // attention pulse on the pin
    } hwn_state_e;

    // received serial frame and its check result
    typedef struct packed {
        logic [FRAME_BITS-1:0] word; // bits in wire order, msb first
        logic parity_err; // odd number of ones seen
    } hwn_frame_s;

    // two signals of a two-way pin
    typedef struct packed {
        logic out; // level driven
        logic oe; // high while driving
    } hwn_drive_s;
endpackage

/* verification/hwn_host_model.sv */
`timescale 1ns/100ps
// behavioural host: server end of the serial link, pull-down on notify pin
module hwn_host_model
    import hwn_pkg::*;
(
    // clock
    input wire logic ref_clk_in,
    // pins toward the device
    output logic select_n_out,
    output logic serial_clk_out,
    output logic client_in_line_out,
    // pins from the device
    input wire logic client_out_line_in,
    input wire hwn_drive_s notify_pin_in,
    output logic notify_level_out
);
    // half period of the 400 ns serial clock, in reference cycles
    localparam int HALF_CYC = 4;
    // pull-down rests the line low whenever the device lets go
    assign notify_level_out =
        notify_pin_in.oe & notify_pin_in.out;
    initial
    begin
        select_n_out = 1'b1;
        serial_clk_out = 1'b0;
        client_in_line_out = 1'b0;
    end
    // select low is a wake request while the port is off
    task automatic select(input logic low);
        @(posedge ref_clk_in);
        select_n_out <= !low;
    endtask
    // one frame msb first; clock idles low, data set while it is low
    task automatic frame(input logic [15:0] wr, output logic [15:0] rd);
        repeat (2 * HALF_CYC) @(posedge ref_clk_in);
        for (int i = MSB; i >= 0; i--)
        begin
            client_in_line_out <= wr[i];
            repeat (HALF_CYC) @(posedge ref_clk_in);
            serial_clk_out <= 1'b1;
            rd[i] = client_out_line_in;
            repeat (HALF_CYC) @(posedge ref_clk_in);
            serial_clk_out <= 1'b0;
        end
        // released data line shows the inverse, never a stale bit
        client_in_line_out <= !wr[0];
    endtask
endmodule

/* verification/tb_top.sv */
`timescale 1ns/100ps
// self-checking bench for the wake and notify pin logic
module tb_top
    import hwn_pkg::*;
;
    // design inputs, all set at time zero
    logic clk = 1'b0;
    logic rst_n = 1'b0;
    logic ser_en = 1'b0;
    logic sw_cfg = 1'b0;
    logic attn = 1'b0;
    logic gmode = 1'b0;
    logic gval = 1'b0;
    logic [15:0] tx_word = 16'ha5c3;
    logic strap = 1'b1;
    // host pins and design outputs
    logic sel_n, sclk, cin, cout, sw_out, wake, dbg, rx_valid, level;
    hwn_drive_s notify_pin, strap_drv;
    hwn_frame_s rx_frame;
    // bookkeeping
    int failures = 0;
    int checks_done = 0;
    int cycles = 0;
    int rx_count = 0;
    logic [31:0] rnd = 32'h0000_88fe;
    logic [15:0] rd;
    logic [15:0] corner [3] = '{16'h0000, 16'hffff, 16'h0001};

    always #25 clk = ~clk;

    hwn_notify u_hwn_notify (
        .ref_clk_in(clk), .rst_n_in(rst_n), .serial_enable_in(ser_en),
        .ps_switch_cfg_in(sw_cfg), .attention_in(attn),
        .gpio_mode_in(gmode), .gpio_value_in(gval), .tx_word_in(tx_word),
        .port_a_bit0_pin_in(sel_n), .serial_clk_pin_in(sclk),
        .client_in_line_in(cin), .debug_strap_pin_in(strap),
        .client_out_line_out(cout), .port_b_bit0_pin_out(notify_pin),
        .power_switch_enable_out(sw_out), .debug_strap_pin_out(strap_drv),
        .wake_irq_out(wake), .background_debug_state_out(dbg),
        .rx_valid_out(rx_valid), .rx_frame_out(rx_frame));

    hwn_host_model u_hwn_host_model (
        .ref_clk_in(clk), .select_n_out(sel_n), .serial_clk_out(sclk),
        .client_in_line_out(cin), .client_out_line_in(cout),
        .notify_pin_in(notify_pin), .notify_level_out(level));

    // cycle ceiling cuts a hang short; frame counter
    always @(posedge clk)
    begin
        cycles++;
        if (rx_valid === 1'b1)
            rx_count++;
        if (cycles == 20000)
        begin
            failures++;
            end_sim();
        end
    end

    // next value of the stimulus shift register
    function automatic logic [31:0] lfsr(input logic [31:0] x);
        return {x[30:0], x[31] ^ x[21] ^ x[1] ^ x[0]};
    endfunction

    // expected read word: upper bits as given, bit0 makes parity even
    function automatic logic [15:0] with_par(input logic [15:0] t);
        return {t[15:1], ^t[15:1]};
    endfunction

    task automatic check(input string what, input logic [15:0] exp,
                         input logic [15:0] got);
        checks_done++;
        if (got !== exp)
        begin
            failures++;
            $display("unexpected %s: expected %h seen %h", what, exp, got);
        end
    endtask

    task automatic end_sim();
        $display("checks %0d, failures %0d", checks_done, failures);
        if (failures == 0 && checks_done > 0)
            $display("Simulation passed");
        else
            $display("Simulation failed");
        $finish;
    endtask

    // reset with a given strap level, held until synchronisers settle
    task automatic do_reset(input logic s);
        rst_n <= 1'b0;
        strap <= s;
        repeat (10) @(posedge clk);
        check("notify oe in reset", 16'h0, notify_pin.oe);
        rst_n <= 1'b1;
        repeat (6) @(posedge clk);
        check("debug state", 16'(!s), dbg);
    endtask

    // select, one frame, then compare both directions
    task automatic xfer(input logic [15:0] wr, input logic [15:0] tx);
        int base;
        tx_word <= tx;
        @(posedge clk);
        u_hwn_host_model.select(1'b1);
        base = rx_count;
        u_hwn_host_model.frame(wr, rd);
        repeat (8) @(posedge clk);
        check("frame count", 16'(base + 1), 16'(rx_count));
        check("rx word", wr, rx_frame.word);
        check("parity err", 16'(^wr), rx_frame.parity_err);
        check("read word", with_par(tx), rd);
    endtask

    // one attention event; measures switch lead and pulse width
    task automatic pulse_test(input logic cfg);
        int lead;
        int width;
        int sw_hi;
        lead = 0;
        width = 0;
        sw_hi = 0;
        sw_cfg <= cfg;
        @(posedge clk);
        attn <= 1'b1;
        @(posedge clk);
        attn <= 1'b0;
        repeat (100)
        begin
            @(posedge clk);
            sw_hi += int'(sw_out === 1'b1);
            if (level === 1'b1)
                width++;
            else if (width == 0 && sw_out === 1'b1)
                lead++;
        end
        check("pulse width", 16'(PULSE_CYC), 16'(width));
        if (cfg)
            check("lead ok", 16'h1,
                  16'(lead >= int'(PS_LEAD_CYC)));
        else
            check("switch idle", 16'h0, 16'(sw_hi));
        $display("test pulse cfg=%0d done", cfg);
    endtask

    initial
    begin
        do_reset(1'b0);
        do_reset(1'b1);
        $display("test reset done");
        // wake request, ready level, session, release
        u_hwn_host_model.select(1'b1);
        repeat (8) @(posedge clk);
        check("wake irq", 16'h1, wake);
        check("ready level", 16'h1, level);
        ser_en <= 1'b1;
        repeat (6) @(posedge clk);
        check("wake when on", 16'h0, wake);
        xfer(16'h3c5a, 16'ha5c3);
        check("ready held", 16'h1, level);
        u_hwn_host_model.select(1'b0);
        repeat (10) @(posedge clk);
        check("ready released", 16'h0, level);
        $display("test wake done");
        // frames: corner words then random ones
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            xfer(i < 3 ? corner[i] : rnd[15:0], rnd[31:16]);
            u_hwn_host_model.select(1'b0);
            repeat (6) @(posedge clk);
        end
        $display("test frames done");
        pulse_test(1'b1);
        pulse_test(1'b0);
        // strap pin as gpio output
        for (int i = 0; i < 6; i++)
        begin
            rnd = lfsr(rnd);
            gmode <= rnd[0];
            gval <= rnd[1];
            repeat (3) @(posedge clk);
            check("gpio drive", {14'h0, rnd[0], rnd[0] & rnd[1]},
                  {14'h0, strap_drv.oe, strap_drv.out});
        end
        $display("test gpio done");
        end_sim();
    end
endmodule
